// ---- rtl/prxm_defs.vh ----
// Constants of the receive-side media-independent output multiplexer
// Functional notes
// - RMII: drive active-high receive error, changing on the reference clock
// - MII and GMII: drive active-high receive error on the receive clock
// - RGMII: control pin carries valid and valid-xor-error; error pin held low
// - RMII: control pin carries combined carrier sense and data valid
// - MII: assert data valid on receive clock while four lanes carry frame
// - GMII: assert data valid on receive clock while eight lanes carry frame
// - GMII: eight data lanes, lane n carries bit n, on receive clock
// - MII: four data lanes on receive clock, lanes 4 to 7 low
// - RGMII: four data lanes on receive clock, lanes 4 to 7 low
// - Any pin without function in the current mode is driven low
// - SGMII: all parallel receive outputs driven low
// - RMII: only lanes 0 and 1 used on reference clock, others low
`ifndef PRXM_DEFS_VH
`define PRXM_DEFS_VH

// Interface mode codes on mode_i
`define PRXM_MODE_W 3
`define PRXM_MODE_GMII 3'h0
`define PRXM_MODE_MII 3'h1
`define PRXM_MODE_RGMII 3'h2
`define PRXM_MODE_RMII 3'h3
`define PRXM_MODE_SGMII 3'h4

// Phase counter: rising receive clock edges per source byte, minus one
`define PRXM_PHASE_W 2
`define PRXM_PHASE_RST 2'h0
`define PRXM_LAST_GMII 2'h0
`define PRXM_LAST_MII 2'h1
`define PRXM_LAST_RGMII 2'h0
`define PRXM_LAST_RMII 2'h3

// Field positions inside a source byte
`define PRXM_LO_NIB 3:0
`define PRXM_HI_NIB 7:4

// Reset values of the pin registers
`define PRXM_RXD_RST 8'h00
`define PRXM_BIT_RST 1'b0
`define PRXM_NIB_ZERO 4'h0
`define PRXM_DIBIT_ZERO 6'h00

// Lanes that carry data in each parallel mode
`define PRXM_MASK_GMII 8'hff
`define PRXM_MASK_NIB 8'h0f
`define PRXM_MASK_DIBIT 8'h03

`endif

// ---- rtl/prxm_rx_mux.v ----
// Receive output multiplexer toward the MAC for GMII, MII, RGMII, RMII and SGMII
`timescale 1ns/1ps
`default_nettype none
`include "prxm_defs.vh"

module prxm_rx_mux (
  // System clock and reset
  input wire clk_sys_i,
  input wire reset_n_i,
  // Mode and receive clock pin (RX_CLK, RXC or REFCLK)
  input wire [2:0] mode_i,
  input wire rx_link_clk_i,
  // Receive byte stream from the PHY data path
  input wire [7:0] rx_data_i,
  input wire rx_dv_i,
  input wire rx_er_i,
  input wire rx_crs_i,
  output reg rx_take_o,
  // Pins toward the MAC
  output reg [7:0] rxd_o,
  output reg rx_er_o,
  output reg rx_ctl_o
);

  // Pins are aligned to the sampled link clock, two to three system clocks late

  // Synchronised reset and link clock history
  wire rst_n;
  wire lclk_s;
  reg lclk_prev_q;
  reg [2:0] mode_q;

  // Byte slot state
  reg [1:0] phase_q;
  reg [1:0] phase_d;
  reg [7:0] byte_q;
  reg dv_q;
  reg er_q;
  reg take;

  // Next pin values
  reg [7:0] rxd_d;
  reg rx_er_d;
  reg rx_ctl_d;
  reg out_ev;
  wire [7:0] lane_en;
  wire [7:0] rxd_lane_d;

  // Edge and selection helpers
  wire rise;
  wire fall;
  wire mode_chg;
  wire [7:0] cur_data;
  wire cur_dv;
  wire cur_er;
  wire [1:0] cur_dibit;

  // Rising edges per source byte minus one in each mode; zero for modes with no parallel path
  function [1:0] last_phase;
    input [2:0] mode;
    begin
      case (mode)
        `PRXM_MODE_GMII: last_phase = `PRXM_LAST_GMII;
        `PRXM_MODE_MII: last_phase = `PRXM_LAST_MII;
        `PRXM_MODE_RGMII: last_phase = `PRXM_LAST_RGMII;
        `PRXM_MODE_RMII: last_phase = `PRXM_LAST_RMII;
        default: last_phase = `PRXM_PHASE_RST;
      endcase
    end
  endfunction

  // True for modes that carry data on the parallel pins
  function parallel_mode;
    input [2:0] mode;
    begin
      case (mode)
        `PRXM_MODE_GMII: parallel_mode = 1'b1;
        `PRXM_MODE_MII: parallel_mode = 1'b1;
        `PRXM_MODE_RGMII: parallel_mode = 1'b1;
        `PRXM_MODE_RMII: parallel_mode = 1'b1;
        default: parallel_mode = 1'b0;
      endcase
    end
  endfunction

  // Reset release through two flops
  prxm_sync u_rst_sync (
    .clk_i(clk_sys_i),
    .rst_n_i(reset_n_i),
    .d_i(1'b1),
    .q_o(rst_n)
  );

  // The receive clock pin is sampled, never used as a clock
  prxm_sync u_lclk_sync (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n),
    .d_i(rx_link_clk_i),
    .q_o(lclk_s)
  );

  assign rise = lclk_s & ~lclk_prev_q;
  assign fall = ~lclk_s & lclk_prev_q;
  assign mode_chg = (mode_i != mode_q);

  // A new byte is taken at the first edge of its slot; the held byte serves the rest
  assign cur_data = take ? rx_data_i : byte_q;
  assign cur_dv = take ? rx_dv_i : dv_q;
  assign cur_er = take ? rx_er_i : er_q;
  assign cur_dibit = cur_data[{phase_q, 1'b0} +: 2];

  always @* begin
    take = rise & ~mode_chg & parallel_mode(mode_q) & (phase_q == `PRXM_PHASE_RST);
    if (phase_q == last_phase(mode_q)) begin
      phase_d = `PRXM_PHASE_RST;
    end else begin
      phase_d = phase_q + 2'h1;
    end
  end

  // Next lane values; every lane without a function in the mode stays low
  always @* begin
    rxd_d = `PRXM_RXD_RST;
    case (mode_q)
      `PRXM_MODE_GMII: begin
        rxd_d = cur_data;
      end
      `PRXM_MODE_MII: begin
        // low nibble first, upper lanes low
        if (phase_q == `PRXM_PHASE_RST) begin
          rxd_d = {`PRXM_NIB_ZERO, cur_data[`PRXM_LO_NIB]};
        end else begin
          rxd_d = {`PRXM_NIB_ZERO, cur_data[`PRXM_HI_NIB]};
        end
      end
      `PRXM_MODE_RGMII: begin
        // four lanes, both edges, upper lanes low
        if (rise) begin
          rxd_d = {`PRXM_NIB_ZERO, cur_data[`PRXM_LO_NIB]};
        end else begin
          rxd_d = {`PRXM_NIB_ZERO, byte_q[`PRXM_HI_NIB]};
        end
      end
      `PRXM_MODE_RMII: begin
        // dibits low first, lanes 2 to 7 low
        rxd_d = {`PRXM_DIBIT_ZERO, cur_dibit};
      end
      default: begin
        // serial mode leaves all lanes low
        rxd_d = `PRXM_RXD_RST;
      end
    endcase
  end

  // Next error and control values, and the link edges that update the pins
  always @* begin
    out_ev = 1'b0;
    rx_er_d = `PRXM_BIT_RST;
    rx_ctl_d = `PRXM_BIT_RST;
    case (mode_q)
      `PRXM_MODE_GMII: begin
        out_ev = rise;
        rx_er_d = cur_er;
        rx_ctl_d = cur_dv;
      end
      `PRXM_MODE_MII: begin
        out_ev = rise;
        rx_er_d = cur_er;
        rx_ctl_d = cur_dv;
      end
      `PRXM_MODE_RGMII: begin
        out_ev = rise | fall;
        // valid on rising, valid xor error on falling, error pin low
        if (rise) begin
          rx_ctl_d = cur_dv;
        end else begin
          rx_ctl_d = dv_q ^ er_q;
        end
      end
      `PRXM_MODE_RMII: begin
        out_ev = rise;
        rx_er_d = cur_er;
        // carrier while present, then valid only on the second dibit of each nibble
        rx_ctl_d = rx_crs_i | (cur_dv & phase_q[0]);
      end
      default: begin
        // serial mode leaves both pins low
        out_ev = rise | fall;
      end
    endcase
  end

  // Lanes that carry data in each mode
  function [7:0] lane_mask;
    input [2:0] mode;
    begin
      case (mode)
        `PRXM_MODE_GMII: lane_mask = `PRXM_MASK_GMII;
        `PRXM_MODE_MII: lane_mask = `PRXM_MASK_NIB;
        `PRXM_MODE_RGMII: lane_mask = `PRXM_MASK_NIB;
        `PRXM_MODE_RMII: lane_mask = `PRXM_MASK_DIBIT;
        default: lane_mask = `PRXM_RXD_RST;
      endcase
    end
  endfunction

  assign lane_en = lane_mask(mode_q);

  // lanes masked low
  // Second guard so a lane outside the mode can never be left high
  genvar lane;
  generate
    for (lane = 0; lane < 8; lane = lane + 1) begin : g_lane
      assign rxd_lane_d[lane] = rxd_d[lane] & lane_en[lane];
    end
  endgenerate

  // Link edge history, registered mode and the take strobe
  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      lclk_prev_q <= 1'b0;
      mode_q <= `PRXM_MODE_SGMII;
      rx_take_o <= 1'b0;
    end else begin
      lclk_prev_q <= lclk_s;
      mode_q <= mode_i;
      rx_take_o <= take;
    end
  end

  // Byte held for the later edges of its slot
  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      byte_q <= `PRXM_RXD_RST;
      dv_q <= `PRXM_BIT_RST;
      er_q <= `PRXM_BIT_RST;
    end else if (take) begin
      byte_q <= rx_data_i;
      dv_q <= rx_dv_i;
      er_q <= rx_er_i;
    end
  end

  // A mode switch restarts the byte slot
  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= `PRXM_PHASE_RST;
    end else if (mode_chg) begin
      phase_q <= `PRXM_PHASE_RST;
    end else if (rise) begin
      phase_q <= phase_d;
    end
  end

  // Lanes idle at once on a mode switch so no stale lane survives it
  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      rxd_o <= `PRXM_RXD_RST;
    end else if (mode_chg) begin
      rxd_o <= `PRXM_RXD_RST;
    end else if (out_ev) begin
      rxd_o <= rxd_lane_d;
    end
  end

  // Error and control pins follow the same update events as the lanes
  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_er_o <= `PRXM_BIT_RST;
      rx_ctl_o <= `PRXM_BIT_RST;
    end else if (mode_chg) begin
      rx_er_o <= `PRXM_BIT_RST;
      rx_ctl_o <= `PRXM_BIT_RST;
    end else if (out_ev) begin
      rx_er_o <= rx_er_d;
      rx_ctl_o <= rx_ctl_d;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/prxm_sync.v ----
// Two-stage synchroniser with asynchronous clear
`timescale 1ns/1ps
`default_nettype none

module prxm_sync (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Level in and synchronised level out
  input wire d_i,
  output wire q_o
);

  reg meta_q;
  reg sync_q;

  // The first stage feeds only the second stage
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule

`default_nettype wire

// ---- sim/prxm_mac_model.sv ----
// Receiving MAC model: latches the pins at each take pulse
`timescale 1ns/1ps
`default_nettype none
module prxm_mac_model (
  input wire clk_i,
  input wire take_i,
  input wire [7:0] rxd_i,
  input wire ctl_i,
  input wire er_i,
  output logic [9:0] got_o,
  output int takes_o
);
  initial takes_o = 0;
  always @(posedge clk_i) begin
    if (take_i) begin
      got_o <= {rxd_i, ctl_i, er_i};
      takes_o <= takes_o + 1;
    end
  end
endmodule
`default_nettype wire

// ---- sim/prxm_rx_mux_bench.sv ----
// Bench for the receive output multiplexer
`timescale 1ns/1ps
`default_nettype none
module prxm_rx_mux_bench;
  logic clk_sys_i = 0, reset_n_i = 0, lclk = 0, dv = 0, er = 0, crs = 0;
  logic [2:0] mode = 3'h4;
  logic [7:0] data = 8'h00, rxd;
  logic take, rx_er, ctl;
  logic [9:0] got;
  int takes, bad_count = 0, comparisons = 0;
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  // Odd start keeps link edges off the system clock edges, at a fixed offset
  initial #37 forever #100 lclk = ~lclk;
  prxm_rx_mux u_prxm_rx_mux (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .mode_i(mode),
    .rx_link_clk_i(lclk), .rx_data_i(data), .rx_dv_i(dv), .rx_er_i(er), .rx_crs_i(crs),
    .rx_take_o(take), .rxd_o(rxd), .rx_er_o(rx_er), .rx_ctl_o(ctl));
  prxm_mac_model u_prxm_mac_model (.clk_i(clk_sys_i), .take_i(take), .rxd_i(rxd),
    .ctl_i(ctl), .er_i(rx_er), .got_o(got), .takes_o(takes));
  task check(input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("comparisons %0d errors %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task send(input logic [2:0] m, input logic [7:0] b, input logic v, input logic e);
    logic [9:0] exp;
    int n;
    @(posedge clk_sys_i);
    {data, dv, er, crs} <= {b, v, e, v};
    n = takes;
    for (int i = 0; i < 400 && takes == n; i++) @(posedge clk_sys_i);
    #1;
    case (m)
      3'h0: exp = {b, v, e};
      3'h1: exp = {4'h0, b[3:0], v, e};
      3'h2: exp = {4'h0, b[3:0], v, 1'b0};
      default: exp = {6'h00, b[1:0], v, e};
    endcase
    check(got, exp);
    if (m == 3'h1) begin
      // High nibble follows on the next link rise, about eight clocks on
      repeat (10) @(posedge clk_sys_i);
      #1;
      check({2'b00, rxd}, {6'h00, b[7:4]});
    end
    if (m == 3'h2) begin
      // High nibble and valid-xor-error follow the link fall, four clocks after the rise
      repeat (3) @(posedge clk_sys_i);
      #1;
      check({rxd, ctl, rx_er}, {4'h0, b[7:4], v ^ e, 1'b0});
    end
  endtask
  task t_modes;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys_i);
      mode <= m[2:0];
      send(m[2:0], 8'ha5, 1'b1, 1'b0);
      send(m[2:0], 8'h3c, 1'b1, 1'b1);
      send(m[2:0], 8'h5a, 1'b0, 1'b0);
    end
  endtask
  task t_sgmii;
    int n;
    @(posedge clk_sys_i);
    mode <= 3'h0;
    send(3'h0, 8'hff, 1'b1, 1'b1);
    n = takes;
    mode <= 3'h4;
    repeat (20) @(posedge clk_sys_i);
    check({rxd, ctl, rx_er}, 10'h000);
    check(10'(takes - n), 10'h000);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    t_modes;
    t_sgmii;
    results;
  end
  initial begin
    #200000;
    bad_count++;
    results;
  end
endmodule
`default_nettype wire

// ---- sim/prxm_rx_mux_monitor.sv ----
// Pin checker for the receive output multiplexer
`timescale 1ns/1ps
`default_nettype none
module prxm_rx_mux_monitor (
  input wire clk_sys_i,
  input wire reset_n_i,
  input wire [2:0] mode_i,
  input wire [7:0] rx_data_i,
  input wire rx_dv_i,
  input wire rx_er_i,
  input wire rx_crs_i,
  input wire rx_take_o,
  input wire [7:0] rxd_o,
  input wire rx_er_o,
  input wire rx_ctl_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  a_unused_low: assert property (
    (mode_i >= 3'h4) [*3] |-> {rxd_o, rx_er_o, rx_ctl_o} == 10'h000) else $error("serial pins");
  a_mii_upper: assert property (
    (mode_i == 3'h1) [*3] |-> rxd_o[7:4] == 4'h0) else $error("mii upper lanes");
  a_rgmii_pins: assert property (
    (mode_i == 3'h2) [*3] |-> rxd_o[7:4] == 4'h0 && !rx_er_o) else $error("rgmii pins");
  a_rmii_upper: assert property (
    (mode_i == 3'h3) [*3] |-> rxd_o[7:2] == 6'h00) else $error("rmii upper lanes");
  a_take_once: assert property (
    rx_take_o |=> !rx_take_o) else $error("take pulse");
  a_gmii_byte: assert property (
    mode_i == 3'h0 && rx_take_o |-> rxd_o == $past(rx_data_i)
    && rx_ctl_o == $past(rx_dv_i) && rx_er_o == $past(rx_er_i)) else $error("gmii byte");
  a_mii_nibble: assert property (
    mode_i == 3'h1 && rx_take_o |-> rxd_o[3:0] == $past(rx_data_i[3:0])
    && rx_ctl_o == $past(rx_dv_i)) else $error("mii nibble");
  a_rmii_dibit: assert property (
    mode_i == 3'h3 && rx_take_o |-> rxd_o[1:0] == $past(rx_data_i[1:0])
    && rx_er_o == $past(rx_er_i)) else $error("rmii dibit");
  a_rmii_crs: assert property (
    mode_i == 3'h3 && rx_take_o |-> rx_ctl_o == $past(rx_crs_i)) else $error("rmii crs_dv");
  a_rgmii_lo: assert property (
    mode_i == 3'h2 && rx_take_o |-> rxd_o[3:0] == $past(rx_data_i[3:0])
    && rx_ctl_o == $past(rx_dv_i)) else $error("rgmii low nibble");
endmodule
bind prxm_rx_mux prxm_rx_mux_monitor u_prxm_rx_mux_monitor (.*);
`default_nettype wire
